// >>> core/amp_regs.svh
/*
  register offsets, field positions, reset values and timing counts of the
  analog mux and pwm control register bank. assumes word-index offsets.
*/
`ifndef AMP_REGS_SVH
`define AMP_REGS_SVH
// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define AMP_IDX_CMP_SEL 8'h9e
`define AMP_IDX_AMP_CTL 8'h9f
`define AMP_IDX_PORT2 8'ha0
`define AMP_IDX_PWM_CTL 8'ha1
`define AMP_IDX_P1_MODE 8'ha2
`define AMP_IDX_MASK_CTL 8'ha7
`define AMP_IDX_DBNC_CTL 8'h9d
`define AMP_IDX_STATUS 8'hb0
// ----------------------------------------
// reset values
// ----------------------------------------
`define AMP_RST_CMP_SEL 8'hf7
`define AMP_RST_AMP_CTL 8'hec
`define AMP_RST_PORT2 8'hff
`define AMP_RST_PWM_CTL 8'h00
`define AMP_RST_P1_MODE 8'h55
`define AMP_RST_MASK_CTL 8'h00
`define AMP_RST_DBNC_CTL 8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define AMP_BIT_NEG_SRC 7
`define AMP_BIT_POS_SRC 3
`define AMP_BIT_PWR_DN 7
`define AMP_BIT_NEG_LVL 4
`define AMP_BIT_G1_EN 5
`define AMP_BIT_CH0_EN 4
`define AMP_BIT_NEG_MSK 1
`define AMP_BIT_POS_MSK 0
`define AMP_BIT_MSK_EN 6
// ----------------------------------------
// debounce counts in system clocks
// ----------------------------------------
`define AMP_DBNC_SHORT 5'd4
`define AMP_DBNC_MID 5'd8
`define AMP_DBNC_LONG 5'd16
`endif

// >>> core/amp_pkg.sv
/*
  types of the analog mux and pwm control register bank.
  assumes nothing beyond the register header.
*/
package amp_pkg;
  typedef enum logic [2:0] {
    AMP_BUS_IDLE = 3'b001,
    AMP_BUS_WRSP = 3'b010,
    AMP_BUS_RRSP = 3'b100
  } amp_bus_e;
  typedef enum logic [1:0] {
    AMP_CK_SYS0 = 2'b00,
    AMP_CK_SYS1 = 2'b01,
    AMP_CK_FRC = 2'b10,
    AMP_CK_FRC2 = 2'b11
  } amp_clk_sel_e;
endpackage

// >>> core/amp_debounce.sv
/*
  comparator raw output debounce filter on the system clock.
  assumes raw_in is already synchronised to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs.svh"
module amp_debounce
  import amp_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic [1:0] sel, // debounce select
  input wire logic raw_in, // synchronised raw level
  output logic filt_out // debounced level
);
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [4:0] need;
  logic filt_ff;
  logic nxt_filt;
  // ----------------------------------------
  // stable-count filter
  // ----------------------------------------
  assign need = (sel == 2'b01) ? `AMP_DBNC_SHORT : (sel == 2'b10) ? `AMP_DBNC_MID : `AMP_DBNC_LONG;
  always_comb begin
    nxt_cnt = 5'h0;
    nxt_filt = filt_ff;
    if (sel == 2'b00) begin
      nxt_filt = raw_in;
    end else if (raw_in != filt_ff) begin
      nxt_cnt = cnt_ff + 5'h1;
      // level must differ for need clocks in a row before it passes
      if (nxt_cnt >= need) begin
        nxt_filt = raw_in;
        nxt_cnt = 5'h0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 5'h0;
      filt_ff <= 1'b1;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      filt_ff <= nxt_filt;
    end
  end
  assign filt_out = filt_ff;
endmodule
`default_nettype wire

// >>> core/amp_mask.sv
/*
  pwm0 output masking: while clear and mask enable are high the two
  outputs take the mask levels. assumes inputs on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module amp_mask
  import amp_pkg::*;
(
  input wire logic ch0_enable, // pwm0 channel enable
  input wire logic clear, // pwm0 clear condition
  input wire logic mask_en, // mask enable
  input wire logic pos_lvl, // positive mask level
  input wire logic neg_lvl, // negative mask level
  input wire logic pos_raw, // pwm0 positive from counter
  input wire logic neg_raw, // pwm0 negative from counter
  output logic pos_out, // masked positive
  output logic neg_out // masked negative
);
  logic masking;
  assign masking = clear & mask_en;
  assign pos_out = masking ? pos_lvl : (ch0_enable & pos_raw);
  assign neg_out = masking ? neg_lvl : (ch0_enable & neg_raw);
endmodule
`default_nettype wire

// >>> core/amp_bank.sv
/*
  analog mux and pwm control register bank behind an axi4-lite slave.
  assumes a master keeping axi4-lite handshakes; one clock, aclk.
*/
// Our own choice: the AXI4-Lite slave port.
// Functional notes
// - neg input source bit 7 resets 1; 0 pin, 1 dac output
// - neg channel bits 6:4 reset 111; 000 ch1, 001/010 ch2, 011 ch4, 1xx open
// - pos source bit 3 resets 0; 0 amplifier output, 1 external pin
// - pos channel bits 2:0 reset 111; 000..011 pins, 1xx open
// - amplifier power down bit 7 resets 1; 0 lets it run
// - amplifier pos input bits 6:5 reset 11; 3.3, 1.4, 1.7, ground
// - bit 4 resets 0; comparator-mode neg level ground or bandgap
// - mode bits 1:0 reset 00, 11 comparator; gain bits 3:2 reset 11
// - port two bits 7:2 plain storage, bits 1:0 pin data, all reset 1
// - pwm clock selects reset 00; sys, sys, fast rc, twice fast rc
// - bit 5 resets 0 and enables pwm group one to six
// - bit 4 resets 0 and enables pwm channel 0
// - bit 1 resets 0; negative mask level under clear and mask enable
// - bit 0 resets 0; positive mask level under clear and mask enable
// - debounce select resets 00; none, 4, 8 or 16 clocks stable
// - mask enable resets 0; outputs take mask levels while clear
// - pin mode fields reset 01; codes 00..11 give modes 0..3
`timescale 1ns/1ps
`default_nettype none
`include "amp_regs.svh"
module amp_bank
  import amp_pkg::*;
#(
  parameter int ADDR_W = 12 // axi address width
) (
  input wire logic aclk, // system clock, 100 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic cmp_raw_pin, // raw comparator output, async
  input wire logic pwm_ch0_clear, // pwm0 clear condition, aclk domain
  input wire logic pwm0_pos_raw, // pwm0 positive from counter
  input wire logic pwm0_neg_raw, // pwm0 negative from counter
  output logic neg_source_select, // 1 dac, 0 external pin
  output logic [3:0] neg_channel_onehot, // neg pin select, ch1 ch2 - ch4
  output logic pos_source_select, // 1 external pin, 0 amplifier
  output logic [3:0] pos_channel_onehot, // pos pin select
  output logic amp_power_down, // amplifier power down
  output logic [1:0] amp_pos_input_select, // amplifier pos input
  output logic amp_neg_level_select, // ground or bandgap reference
  output logic [1:0] amp_gain_select, // gain code
  output logic [1:0] amp_mode_select, // mode code
  output logic amp_cmp_mode, // amplifier in comparator mode
  output logic [1:0] port2_pin_data, // pinned port two lines
  output logic [1:0] pwm_group1_clock_select, // group 1 clock code
  output logic pwm_group1_enable, // group 1 enable
  output logic pwm_ch0_enable, // channel 0 enable
  output logic [1:0] pwm_ch0_clock_select, // channel 0 clock code
  output logic [7:0] pin_mode_low, // port one mode low register
  output logic pwm0_pos_out, // masked pwm0 positive
  output logic pwm0_neg_out, // masked pwm0 negative
  output logic cmp_filtered // debounced comparator level
);
  // the index decode needs bits 9:2 and a zero check above them
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_w_bad
    $error("ADDR_W must be 12 to 32");
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] cmp_sel_ff, amp_ctl_ff, port2_ff, pwm_ctl_ff, p1_mode_ff, mask_ctl_ff, dbnc_ctl_ff;
  amp_bus_e bus_ff, nxt_bus;
  logic aw_ok_ff, w_ok_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0] wbyte_ff;
  logic wstrb0_ff;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] bresp_ff, rresp_ff;
  logic sync1_ff, sync2_ff;
  // ----------------------------------------
  // axi4-lite handshake
  // ----------------------------------------
  wire aw_take = ce && bus_ff == AMP_BUS_IDLE && !aw_ok_ff && s_axi_awvalid;
  wire w_take = ce && bus_ff == AMP_BUS_IDLE && !w_ok_ff && s_axi_wvalid;
  wire wr_go = ce && bus_ff == AMP_BUS_IDLE && aw_ok_ff && w_ok_ff;
  wire rd_go = ce && bus_ff == AMP_BUS_IDLE && !wr_go && !aw_ok_ff && !w_ok_ff && s_axi_arvalid;
  wire [7:0] wr_idx = awaddr_ff[9:2];
  wire wr_aligned = awaddr_ff[1:0] == 2'b00 && awaddr_ff[ADDR_W-1:10] == '0;
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire rd_aligned = s_axi_araddr[1:0] == 2'b00 && s_axi_araddr[ADDR_W-1:10] == '0;
  wire wr_hit_cmp = wr_aligned && wr_idx == `AMP_IDX_CMP_SEL;
  wire wr_hit_amp = wr_aligned && wr_idx == `AMP_IDX_AMP_CTL;
  wire wr_hit_p2 = wr_aligned && wr_idx == `AMP_IDX_PORT2;
  wire wr_hit_pwm = wr_aligned && wr_idx == `AMP_IDX_PWM_CTL;
  wire wr_hit_p1 = wr_aligned && wr_idx == `AMP_IDX_P1_MODE;
  wire wr_hit_msk = wr_aligned && wr_idx == `AMP_IDX_MASK_CTL;
  wire wr_hit_dbn = wr_aligned && wr_idx == `AMP_IDX_DBNC_CTL;
  wire wr_mapped = wr_hit_cmp | wr_hit_amp | wr_hit_p2 | wr_hit_pwm | wr_hit_p1 | wr_hit_msk | wr_hit_dbn;
  wire wr_en = wr_go && wstrb0_ff;
  // readies drop while ce is low, else a master would see a beat taken that the frozen slave never stored
  assign s_axi_awready = ce && bus_ff == AMP_BUS_IDLE && !aw_ok_ff;
  assign s_axi_wready = ce && bus_ff == AMP_BUS_IDLE && !w_ok_ff;
  assign s_axi_arready = ce && bus_ff == AMP_BUS_IDLE && !aw_ok_ff && !w_ok_ff;
  assign s_axi_bvalid = bus_ff == AMP_BUS_WRSP;
  assign s_axi_rvalid = bus_ff == AMP_BUS_RRSP;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  always_comb begin
    nxt_bus = bus_ff;
    case (bus_ff)
      AMP_BUS_IDLE: begin
        if (wr_go) begin
          nxt_bus = AMP_BUS_WRSP;
        end else if (rd_go) begin
          nxt_bus = AMP_BUS_RRSP;
        end
      end
      AMP_BUS_WRSP: begin
        if (s_axi_bready) begin
          nxt_bus = AMP_BUS_IDLE;
        end
      end
      AMP_BUS_RRSP: begin
        if (s_axi_rready) begin
          nxt_bus = AMP_BUS_IDLE;
        end
      end
      default: begin
        nxt_bus = AMP_BUS_IDLE;
      end
    endcase
  end
  // ----------------------------------------
  // read mux, stored value returned as is
  // ----------------------------------------
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_aligned) begin
      case (rd_idx)
        `AMP_IDX_CMP_SEL: nxt_rdata = {24'h00_0000, cmp_sel_ff};
        `AMP_IDX_AMP_CTL: nxt_rdata = {24'h00_0000, amp_ctl_ff};
        `AMP_IDX_PORT2: nxt_rdata = {24'h00_0000, port2_ff};
        `AMP_IDX_PWM_CTL: nxt_rdata = {24'h00_0000, pwm_ctl_ff};
        `AMP_IDX_P1_MODE: nxt_rdata = {24'h00_0000, p1_mode_ff};
        `AMP_IDX_MASK_CTL: nxt_rdata = {24'h00_0000, mask_ctl_ff};
        `AMP_IDX_DBNC_CTL: nxt_rdata = {24'h00_0000, dbnc_ctl_ff};
        `AMP_IDX_STATUS: nxt_rdata = {30'h0000_0000, pwm0_pos_out, cmp_filtered};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
  end
  wire rd_mapped = rd_aligned && (rd_idx == `AMP_IDX_CMP_SEL || rd_idx == `AMP_IDX_AMP_CTL
    || rd_idx == `AMP_IDX_PORT2 || rd_idx == `AMP_IDX_PWM_CTL || rd_idx == `AMP_IDX_P1_MODE
    || rd_idx == `AMP_IDX_MASK_CTL || rd_idx == `AMP_IDX_DBNC_CTL || rd_idx == `AMP_IDX_STATUS);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_ff <= AMP_BUS_IDLE;
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      awaddr_ff <= '0;
      wbyte_ff <= 8'h00;
      wstrb0_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      bresp_ff <= 2'b00;
      rresp_ff <= 2'b00;
    end else if (ce) begin
      bus_ff <= nxt_bus;
      if (aw_take) begin
        aw_ok_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_ok_ff <= 1'b0;
      end
      if (w_take) begin
        w_ok_ff <= 1'b1;
        wbyte_ff <= s_axi_wdata[7:0];
        wstrb0_ff <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_ok_ff <= 1'b0;
      end
      if (wr_go) begin
        bresp_ff <= wr_mapped ? 2'b00 : 2'b10;
      end
      if (rd_go) begin
        rdata_ff <= nxt_rdata;
        rresp_ff <= rd_mapped ? 2'b00 : 2'b10;
      end
    end
  end
  // ----------------------------------------
  // register storage, reserved codes kept
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_sel_ff <= `AMP_RST_CMP_SEL;
      amp_ctl_ff <= `AMP_RST_AMP_CTL;
      port2_ff <= `AMP_RST_PORT2;
      pwm_ctl_ff <= `AMP_RST_PWM_CTL;
      p1_mode_ff <= `AMP_RST_P1_MODE;
      mask_ctl_ff <= `AMP_RST_MASK_CTL;
      dbnc_ctl_ff <= `AMP_RST_DBNC_CTL;
    end else if (wr_en) begin
      if (wr_hit_cmp) cmp_sel_ff <= wbyte_ff;
      if (wr_hit_amp) amp_ctl_ff <= wbyte_ff;
      if (wr_hit_p2) port2_ff <= wbyte_ff;
      if (wr_hit_pwm) pwm_ctl_ff <= wbyte_ff;
      if (wr_hit_p1) p1_mode_ff <= wbyte_ff;
      if (wr_hit_msk) mask_ctl_ff <= wbyte_ff;
      if (wr_hit_dbn) dbnc_ctl_ff <= wbyte_ff;
    end
  end
  // ----------------------------------------
  // comparator input synchroniser and filter
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else if (ce) begin
      sync1_ff <= cmp_raw_pin;
      sync2_ff <= sync1_ff;
    end
  end
  logic filt_w, pos_w, neg_w;
  amp_debounce i_amp_debounce (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .sel(dbnc_ctl_ff[1:0]),
    .raw_in(sync2_ff),
    .filt_out(filt_w)
  );
  amp_mask i_amp_mask (
    .ch0_enable(pwm_ctl_ff[`AMP_BIT_CH0_EN]),
    .clear(pwm_ch0_clear),
    .mask_en(mask_ctl_ff[`AMP_BIT_MSK_EN]),
    .pos_lvl(pwm_ctl_ff[`AMP_BIT_POS_MSK]),
    .neg_lvl(pwm_ctl_ff[`AMP_BIT_NEG_MSK]),
    .pos_raw(pwm0_pos_raw),
    .neg_raw(pwm0_neg_raw),
    .pos_out(pos_w),
    .neg_out(neg_w)
  );
  // ----------------------------------------
  // decoded outputs, registered
  // ----------------------------------------
  wire [3:0] neg_oh_w = cmp_sel_ff[6] ? 4'h0 :
    (cmp_sel_ff[5:4] == 2'b00) ? 4'h1 : (cmp_sel_ff[5:4] == 2'b11) ? 4'h8 : 4'h2;
  wire [3:0] pos_oh_w = cmp_sel_ff[2] ? 4'h0 : (4'h1 << cmp_sel_ff[1:0]);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      neg_source_select <= 1'b1;
      neg_channel_onehot <= 4'h0;
      pos_source_select <= 1'b0;
      pos_channel_onehot <= 4'h0;
      amp_power_down <= 1'b1;
      amp_pos_input_select <= 2'b11;
      amp_neg_level_select <= 1'b0;
      amp_gain_select <= 2'b11;
      amp_mode_select <= 2'b00;
      amp_cmp_mode <= 1'b0;
      port2_pin_data <= 2'b11;
      pwm_group1_clock_select <= 2'b00;
      pwm_group1_enable <= 1'b0;
      pwm_ch0_enable <= 1'b0;
      pwm_ch0_clock_select <= 2'b00;
      pin_mode_low <= `AMP_RST_P1_MODE;
      pwm0_pos_out <= 1'b0;
      pwm0_neg_out <= 1'b0;
      cmp_filtered <= 1'b1;
    end else if (ce) begin
      neg_source_select <= cmp_sel_ff[`AMP_BIT_NEG_SRC];
      neg_channel_onehot <= neg_oh_w;
      pos_source_select <= cmp_sel_ff[`AMP_BIT_POS_SRC];
      pos_channel_onehot <= pos_oh_w;
      amp_power_down <= amp_ctl_ff[`AMP_BIT_PWR_DN];
      amp_pos_input_select <= amp_ctl_ff[6:5];
      amp_neg_level_select <= amp_ctl_ff[`AMP_BIT_NEG_LVL];
      amp_gain_select <= amp_ctl_ff[3:2];
      amp_mode_select <= amp_ctl_ff[1:0];
      amp_cmp_mode <= amp_ctl_ff[1:0] == 2'b11;
      port2_pin_data <= port2_ff[1:0];
      pwm_group1_clock_select <= pwm_ctl_ff[7:6];
      pwm_group1_enable <= pwm_ctl_ff[`AMP_BIT_G1_EN];
      pwm_ch0_enable <= pwm_ctl_ff[`AMP_BIT_CH0_EN];
      pwm_ch0_clock_select <= pwm_ctl_ff[3:2];
      pin_mode_low <= p1_mode_ff;
      pwm0_pos_out <= pos_w;
      pwm0_neg_out <= neg_w;
      cmp_filtered <= filt_w;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_neg_src_follow: assert property (ce ##1 ce |-> neg_source_select == $past(cmp_sel_ff[7]))
    else $error("neg source output does not follow register");
  a_neg_chan_open: assert property (ce && cmp_sel_ff[6] |=> neg_channel_onehot == 4'h0)
    else $error("neg channel not open for 1xx");
  a_pos_src_follow: assert property (ce |=> pos_source_select == $past(cmp_sel_ff[3]))
    else $error("pos source output wrong");
  a_pos_chan_onehot: assert property (ce && !cmp_sel_ff[2] |=> $onehot(pos_channel_onehot))
    else $error("pos channel not one-hot");
  a_amp_pd_follow: assert property (ce |=> amp_power_down == $past(amp_ctl_ff[7]))
    else $error("power down output wrong");
  a_cmp_mode_dec: assert property (ce |=> amp_cmp_mode == ($past(amp_ctl_ff[1:0]) == 2'b11))
    else $error("comparator mode decode wrong");
  a_wr_one_cycle: assert property (wr_en && wr_hit_pwm |=> pwm_ctl_ff == $past(wbyte_ff))
    else $error("write not stored in one cycle");
  a_mask_drive: assert property (ce && pwm_ch0_clear && mask_ctl_ff[`AMP_BIT_MSK_EN]
    |=> pwm0_pos_out == $past(pwm_ctl_ff[0]) && pwm0_neg_out == $past(pwm_ctl_ff[1]))
    else $error("mask level not driven");
  a_p2_store: assert property (wr_en && wr_hit_p2 |=> port2_ff[7:2] == $past(wbyte_ff[7:2]))
    else $error("port two storage bits lost");
  a_bresp_wait: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  c_write: cover property (wr_go ##[1:5] s_axi_bvalid && s_axi_bready);
  c_read: cover property (rd_go ##1 s_axi_rvalid && s_axi_rready);
  c_mask: cover property (pwm0_pos_out && pwm_ctl_ff[0] && mask_ctl_ff[6]);
  c_dbnc: cover property (dbnc_ctl_ff[1:0] == 2'b11 && $changed(cmp_filtered));
endmodule
`default_nettype wire

// >>> dv/amp_bank_tb_top.sv
/*
  self-checking testbench of the analog mux and pwm control register bank.
  assumes the bank answers over axi4-lite on aclk, reset synchronous, low.
*/
`timescale 1ns/1ps
`default_nettype none
module amp_bank_tb_top;
  import amp_pkg::*;
  typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] ex;} amp_row_s;
  logic aclk = 0, aresetn = 0, ce = 1, raw = 1, clr = 0, praw = 0, nraw = 0;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0, noh, poh;
  logic awr, wrd, bv, arr, rv, nsrc, psrc, apd, anl, acm, g1e, c0e, po, no, cf;
  logic [1:0] bresp, rresp, rsp, api, ag, am, p2, g1c, c0c;
  logic [7:0] pml;
  int fail_count = 0, comparisons = 0;
  amp_row_s rows [8] = '{'{8'h9e, 8'h08, 8'h08}, '{8'h9f, 8'h01, 8'h01}, '{8'h9f, 8'h12, 8'h12},
    '{8'ha0, 8'ha9, 8'ha9}, '{8'ha1, 8'hff, 8'hff}, '{8'ha2, 8'hc4, 8'hc4},
    '{8'h9d, 8'h03, 8'h03}, '{8'ha7, 8'h40, 8'h40}};
  always #5 aclk = ~aclk;
  amp_bank i_amp_bank (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .cmp_raw_pin(raw), .pwm_ch0_clear(clr), .pwm0_pos_raw(praw), .pwm0_neg_raw(nraw),
    .neg_source_select(nsrc), .neg_channel_onehot(noh), .pos_source_select(psrc),
    .pos_channel_onehot(poh), .amp_power_down(apd), .amp_pos_input_select(api),
    .amp_neg_level_select(anl), .amp_gain_select(ag), .amp_mode_select(am), .amp_cmp_mode(acm),
    .port2_pin_data(p2), .pwm_group1_clock_select(g1c), .pwm_group1_enable(g1e),
    .pwm_ch0_enable(c0e), .pwm_ch0_clock_select(c0c), .pin_mode_low(pml), .pwm0_pos_out(po),
    .pwm0_neg_out(no), .cmp_filtered(cf));
  // ----------------------------------------
  // checks and bus tasks
  // ----------------------------------------
  task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
    chk(32'(e), 32'(g));
  endtask
  function automatic logic [11:0] ba(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  // bus is judged at the falling edge, so the next rising edge's transfer is known
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] e);
    bit ta, tw, tb, done;
    done = 0;
    @(posedge aclk);
    awaddr <= a;
    awv <= 1;
    wdata <= 32'(d);
    wstrb <= s;
    wv <= 1;
    bready <= 1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = awv && awr;
      tw = wv && wrd;
      tb = bv && bready;
      rsp = bresp;
      @(posedge aclk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
      if (tb) bready <= 0;
      done = tb;
    end
    if (!done) begin
      fail_count++;
      end_of_test();
    end else begin
      chk_resp(e, rsp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    bit ta, tr, done;
    done = 0;
    @(posedge aclk);
    araddr <= a;
    arv <= 1;
    rready <= 1;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge aclk);
      ta = arv && arr;
      tr = rv && rready;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ta) arv <= 0;
      if (tr) rready <= 0;
      done = tr;
    end
    if (!done) begin
      fail_count++;
      end_of_test();
    end else begin
      chk(32'(e), rd);
      chk_resp(er, rsp);
    end
  endtask
  task automatic settle;
    repeat (2) @(negedge aclk);
  endtask
  function automatic logic [3:0] nexp(input logic [2:0] c);
    case (c)
      3'd0: return 4'h1;
      3'd1, 3'd2: return 4'h2;
      3'd3: return 4'h8;
      default: return 4'h0;
    endcase
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    settle();
    chk(32'({nsrc, apd, api, ag, am}), 32'h0000_00fc);
    chk(32'({noh, poh, p2, pml}), 32'h0000_0355);
    rdc(ba(8'h9e), 8'hf7, 2'b00);
    rdc(ba(8'h9f), 8'hec, 2'b00);
    rdc(ba(8'ha0), 8'hff, 2'b00);
    rdc(ba(8'ha1), 8'h00, 2'b00);
    rdc(ba(8'ha2), 8'h55, 2'b00);
    rdc(ba(8'h9d), 8'h00, 2'b00);
    rdc(ba(8'ha7), 8'h00, 2'b00);
    foreach (rows[i]) begin
      wr(ba(rows[i].idx), rows[i].wd, 4'hf, 2'b00);
      rdc(ba(rows[i].idx), rows[i].ex, 2'b00);
    end
    settle();
    chk(32'({p2, pml}), 32'h0000_01c4);
    for (int c = 0; c < 8; c++) begin
      v = {c[0], c[2:0], ~c[0], c[2:0]};
      wr(ba(8'h9e), v, 4'hf, 2'b00);
      settle();
      chk(32'({nsrc, psrc, noh}), 32'({c[0], ~c[0], nexp(c[2:0])}));
      chk(32'(poh), (c < 4) ? 32'(1 << c) : 32'h0000_0000);
    end
    for (int k = 0; k < 4; k++) begin
      v = {k[0], k[1:0], k[1], k[1:0], k[1:0]};
      wr(ba(8'h9f), v, 4'hf, 2'b00);
      settle();
      chk(32'({apd, api, anl, ag, am}), 32'(v));
      chk(32'(acm), 32'(k == 3));
      v = {k[1:0], k[0], k[1], k[1:0], ~k[1:0]};
      wr(ba(8'ha1), v, 4'hf, 2'b00);
      settle();
      chk(32'({g1c, g1e, c0e, c0c}), 32'(v[7:2]));
    end
    // mask levels only win while clear and mask enable are both high
    wr(ba(8'ha7), 8'h40, 4'hf, 2'b00);
    wr(ba(8'ha1), 8'h12, 4'hf, 2'b00);
    @(posedge aclk);
    clr <= 1;
    praw <= 1;
    settle();
    chk(32'({po, no}), 32'h0000_0001);
    @(posedge aclk);
    clr <= 0;
    settle();
    chk(32'({po, no}), 32'h0000_0002);
    wr(ba(8'ha7), 8'h00, 4'hf, 2'b00);
    @(posedge aclk);
    clr <= 1;
    settle();
    chk(32'({po, no}), 32'h0000_0002);
    wr(ba(8'ha0), 8'h00, 4'hf, 2'b00);
    settle();
    chk(32'(p2), 32'h0000_0000);
    wr(ba(8'ha0), 8'h5a, 4'h0, 2'b00);
    wr(12'h281, 8'h5a, 4'hf, 2'b10);
    wr(12'h300, 8'h5a, 4'hf, 2'b10);
    rdc(12'h300, 8'h00, 2'b10);
    rdc(ba(8'ha0), 8'h00, 2'b00);
    // debounce select is 16 clocks here: 2 sync stages, 16 counts, output flop
    @(posedge aclk);
    raw <= 0;
    repeat (17) @(negedge aclk);
    chk(32'(cf), 32'h0000_0001);
    repeat (4) @(negedge aclk);
    chk(32'(cf), 32'h0000_0000);
    rdc(ba(8'hb0), 8'h02, 2'b00);
    // ce low freezes the synchroniser and the filter
    @(posedge aclk);
    ce <= 0;
    raw <= 1;
    repeat (30) @(negedge aclk);
    chk(32'(cf), 32'h0000_0000);
    @(posedge aclk);
    ce <= 1;
    repeat (24) @(negedge aclk);
    chk(32'(cf), 32'h0000_0001);
    @(posedge aclk);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rdc(ba(8'h9e), 8'hf7, 2'b00);
    rdc(ba(8'ha0), 8'hff, 2'b00);
    end_of_test();
  end
endmodule
`default_nettype wire
